// [eeprom_pkg.sv]
package eeprom_pkg;

    // ==========================================================
    // Array organisation
    // ==========================================================
    localparam int          ARRAY_BYTES   = 32768;
    localparam int          ADDR_W        = 15;
    localparam int          BYTE_W        = 8;
    localparam int          PAGE_BYTES    = 64;
    localparam int          PAGE_W        = 6;
    localparam int          BYTE_BITS     = 8;

    // ==========================================================
    // Device address byte layout
    // ==========================================================
    localparam int          TYPE_MSB      = 7;
    localparam int          TYPE_LSB      = 4;
    localparam int          HWADDR_MSB    = 3;
    localparam int          HWADDR_LSB    = 1;
    localparam int          RW_BIT        = 0;
    // Type codes for main array and identification page
    localparam logic [3:0]  TYPE_ARRAY    = 4'ha;
    localparam logic [3:0]  TYPE_IDPAGE   = 4'hb;
    // Word address bit that turns an id page write into a lock
    localparam int          LOCK_ADDR_BIT = 10;

    // ==========================================================
    // Self-timed programming cycle
    // ==========================================================
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          PROG_TIME_MS  = 5;
    localparam int          PROG_CYCLES   =
        (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int          PROG_CNT_W    = 20;

    // ==========================================================
    // Synchroniser reset levels
    // ==========================================================
    localparam logic        SCL_RST       = 1'b1;
    localparam logic        SDA_RST       = 1'b1;
    localparam logic        WP_RST        = 1'b0;

    // ==========================================================
    // Protocol states
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b010,
        ST_TX   = 3'b011,
        ST_RACK = 3'b100
    } proto_state_t;

endpackage

// [pin_sync.sv]
module pin_sync (
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       scl_pin_i,
    input  wire logic       sda_pin_i,
    input  wire logic       wp_pin_i,
    input  wire logic [2:0] hw_addr_pin_i,
    output logic            scl_rise_o,
    output logic            scl_fall_o,
    output logic            start_o,
    output logic            stop_o,
    output logic            sda_o,
    output logic            wp_o,
    output logic [2:0]      hw_addr_o
);

    // ==========================================================
    // Two-stage synchronisers
    // ==========================================================
    logic [5:0] meta;
    logic [5:0] sync;
    logic       scl_d;
    logic       sda_d;

    localparam logic [5:0] SYNC_RST = {3'h0, eeprom_pkg::WP_RST,
        eeprom_pkg::SDA_RST, eeprom_pkg::SCL_RST};

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= SYNC_RST;
            sync <= SYNC_RST;
        end else begin
            meta <= {hw_addr_pin_i, wp_pin_i, sda_pin_i, scl_pin_i};
            sync <= meta;
        end
    end

    // ==========================================================
    // Edge and condition detection
    // ==========================================================
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_d <= eeprom_pkg::SCL_RST;
            sda_d <= eeprom_pkg::SDA_RST;
        end else begin
            scl_d <= sync[0];
            sda_d <= sync[1];
        end
    end

    assign scl_rise_o = sync[0] & ~scl_d;
    assign scl_fall_o = ~sync[0] & scl_d;
    assign start_o    = sync[0] & scl_d & sda_d & ~sync[1];
    assign stop_o     = sync[0] & scl_d & ~sda_d & sync[1];
    assign sda_o      = sync[1];
    assign wp_o       = sync[2];
    assign hw_addr_o  = sync[5:3];

endmodule // pin_sync

// [serial_eeprom_pin_interface.sv]
// Notes on behaviour
// - Incoming bits are sampled on each rising serial clock edge.
// - Read data changes only after a falling serial clock edge.
// - Data line is open drain: pulled low or released, never driven high.
// - Three hardware address inputs must match the address byte bits.
// - Write protect high blocks every write; low allows writes.
// - Undriven write protect has no internal pull-down; only the testbench's tri0 wire makes it read low.
// - Main array holds 32768 bytes of eight bits, each addressable.
// - Page writes carry up to 64 bytes; partial pages are accepted.
// - Programming runs self-timed and completes within 5 ms.
// - Random reads and sequential reads of consecutive bytes are supported.
// - Extra 64-byte id page becomes read-only once locked, until the next reset.
// - Bytes go MSB first, then a ninth clock carries ACK or NACK.
// - SDA fall with SCL high is start; rise is stop.
// - Address byte: type in bits 7..4, hardware bits, read in bit 0.
// - Matching address byte is acknowledged unless programming is busy; mismatch returns to standby.
module serial_eeprom_pin_interface #(
    parameter int ARRAY_BYTES = eeprom_pkg::ARRAY_BYTES,
    parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       wp_i,
    input  wire logic       hw_addr_bit_zero_i,
    input  wire logic       hw_addr_bit_one_i,
    input  wire logic       hw_addr_bit_two_i,
    output logic            prog_busy_o
);

    localparam int AW = eeprom_pkg::ADDR_W;
    localparam int PW = eeprom_pkg::PAGE_W;
    localparam int CW = eeprom_pkg::PROG_CNT_W;
    localparam int NP = eeprom_pkg::PAGE_BYTES;
    localparam logic [CW-1:0] PROG_LOAD = CW'(PROG_CYCLES);

    // ==========================================================
    // Pin synchronisation
    // ==========================================================
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic       sda_in;
    logic       wp;
    logic [2:0] hw_addr;

    pin_sync u_pin_sync (
        .core_clk_i    (core_clk_i),
        .resetn_i      (resetn_i),
        .scl_pin_i     (scl_i),
        .sda_pin_i     (sda_i),
        .wp_pin_i      (wp_i),
        .hw_addr_pin_i ({hw_addr_bit_two_i, hw_addr_bit_one_i,
                         hw_addr_bit_zero_i}),
        .scl_rise_o    (scl_rise),
        .scl_fall_o    (scl_fall),
        .start_o       (start_cond),
        .stop_o        (stop_cond),
        .sda_o         (sda_in),
        .wp_o          (wp),
        .hw_addr_o     (hw_addr)
    );

    // ==========================================================
    // Storage
    // ==========================================================
    logic [7:0]      mem [ARRAY_BYTES];
    logic [7:0]      id_page [NP];
    logic [7:0]      page_buf [NP];
    logic [NP-1:0]   page_mask;
    logic            id_locked;

    // ==========================================================
    // Protocol state
    // ==========================================================
    eeprom_pkg::proto_state_t state;
    logic [7:0]      shift;
    logic [3:0]      bit_cnt;
    logic            byte_done;
    logic [1:0]      byte_idx;
    logic            rd_mode;
    logic            is_id;
    logic            ack_ok;
    logic [AW-1:0]   ptr;
    logic [AW-1:0]   wr_base;
    logic            lock_req;
    logic [7:0]      tx_byte;
    logic [CW-1:0]   prog_cnt;
    logic            prog_start;
    logic            prog_done;

    function automatic logic addr_match(input logic [7:0] b,
                                        input logic [2:0] hw);
        logic type_ok;
        type_ok = (b[eeprom_pkg::TYPE_MSB:eeprom_pkg::TYPE_LSB]
                       == eeprom_pkg::TYPE_ARRAY) ||
                  (b[eeprom_pkg::TYPE_MSB:eeprom_pkg::TYPE_LSB]
                       == eeprom_pkg::TYPE_IDPAGE);
        return type_ok &&
            (b[eeprom_pkg::HWADDR_MSB:eeprom_pkg::HWADDR_LSB] == hw);
    endfunction

    function automatic logic [AW-1:0] page_next(input logic [AW-1:0] a);
        return {a[AW-1:PW], a[PW-1:0] + 6'h01};
    endfunction

    // Read source for the current pointer
    logic [7:0] rd_data;
    assign rd_data = is_id ? id_page[ptr[PW-1:0]] : mem[ptr];

    // Stop ends a write with buffered data: launch programming
    assign prog_start = stop_cond && !rd_mode && (state != eeprom_pkg::ST_IDLE)
        && (page_mask != '0 || lock_req) && !wp && !prog_busy_o;
    assign prog_done  = prog_busy_o && (prog_cnt == CW'(1));

    // ==========================================================
    // Byte engine
    // ==========================================================
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state     <= eeprom_pkg::ST_IDLE;
            shift     <= 8'h00;
            bit_cnt   <= 4'h0;
            byte_done <= 1'b0;
            byte_idx  <= 2'h0;
            rd_mode   <= 1'b0;
            is_id     <= 1'b0;
            ack_ok    <= 1'b0;
            tx_byte   <= 8'h00;
            sda_oe_o  <= 1'b0;
        end else if (start_cond) begin
            state     <= eeprom_pkg::ST_RX;
            bit_cnt   <= 4'h0;
            byte_done <= 1'b0;
            byte_idx  <= 2'h0;
            rd_mode   <= 1'b0;
            sda_oe_o  <= 1'b0;
        end else if (stop_cond) begin
            state     <= eeprom_pkg::ST_IDLE;
            sda_oe_o  <= 1'b0;
        end else begin
            unique case (state)
                eeprom_pkg::ST_IDLE: begin
                    sda_oe_o <= 1'b0;
                end
                eeprom_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shift     <= {shift[6:0], sda_in};
                        bit_cnt   <= bit_cnt + 4'h1;
                        byte_done <= (bit_cnt
                                      == 4'(eeprom_pkg::BYTE_BITS - 1));
                    end else if (scl_fall && byte_done) begin
                        byte_done <= 1'b0;
                        bit_cnt   <= 4'h0;
                        if (byte_idx == 2'h0) begin
                            if (addr_match(shift, hw_addr)
                                    && !prog_busy_o) begin
                                state    <= eeprom_pkg::ST_ACK;
                                sda_oe_o <= 1'b1;
                                ack_ok   <= 1'b1;
                                rd_mode  <= shift[eeprom_pkg::RW_BIT];
                                is_id    <= shift[eeprom_pkg::TYPE_LSB];
                                byte_idx <= 2'h1;
                            end else begin
                                state    <= eeprom_pkg::ST_IDLE;
                            end
                        end else begin
                            // Data bytes are refused while protected
                            ack_ok   <= !(byte_idx == 2'h3 &&
                                          (wp || (is_id && id_locked)));
                            sda_oe_o <= !(byte_idx == 2'h3 &&
                                          (wp || (is_id && id_locked)));
                            state    <= eeprom_pkg::ST_ACK;
                            if (byte_idx != 2'h3) begin
                                byte_idx <= byte_idx + 2'h1;
                            end
                        end
                    end
                end
                eeprom_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (!ack_ok) begin
                            sda_oe_o <= 1'b0;
                            state    <= eeprom_pkg::ST_IDLE;
                        end else if (rd_mode) begin
                            tx_byte  <= {rd_data[6:0], 1'b0};
                            sda_oe_o <= ~rd_data[7];
                            bit_cnt  <= 4'h1;
                            state    <= eeprom_pkg::ST_TX;
                        end else begin
                            sda_oe_o <= 1'b0;
                            state    <= eeprom_pkg::ST_RX;
                        end
                    end
                end
                eeprom_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'(eeprom_pkg::BYTE_BITS)) begin
                            sda_oe_o <= 1'b0;
                            state    <= eeprom_pkg::ST_RACK;
                        end else begin
                            sda_oe_o <= ~tx_byte[7];
                            tx_byte  <= {tx_byte[6:0], 1'b0};
                            bit_cnt  <= bit_cnt + 4'h1;
                        end
                    end
                end
                eeprom_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        state <= sda_in ? eeprom_pkg::ST_IDLE
                                        : eeprom_pkg::ST_ACK;
                        ack_ok <= ~sda_in;
                    end
                end
                default: begin
                    state    <= eeprom_pkg::ST_IDLE;
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Address pointer and page buffer
    // ==========================================================
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ptr       <= '0;
            wr_base   <= '0;
            page_mask <= '0;
            lock_req  <= 1'b0;
        // A polling start must not drop the page being programmed
        end else if ((start_cond && !prog_busy_o) || prog_done) begin
            page_mask <= '0;
            lock_req  <= 1'b0;
        end else if (state == eeprom_pkg::ST_RX && scl_fall && byte_done) begin
            if (byte_idx == 2'h1) begin
                ptr[AW-1:8] <= shift[AW-9:0];
            end else if (byte_idx == 2'h2) begin
                ptr[7:0]  <= shift;
                wr_base   <= {ptr[AW-1:8], shift[7:PW], 6'h00};
                lock_req  <= is_id && ptr[eeprom_pkg::LOCK_ADDR_BIT];
            end else if (byte_idx == 2'h3 && !wp
                         && !(is_id && id_locked)) begin
                page_mask[ptr[PW-1:0]] <= 1'b1;
                ptr <= page_next(ptr);
            end
        end else if (state == eeprom_pkg::ST_RACK && scl_rise && !sda_in) begin
            ptr <= ptr + AW'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (state == eeprom_pkg::ST_RX && scl_fall && byte_done
                && byte_idx == 2'h3) begin
            page_buf[ptr[PW-1:0]] <= shift;
        end
    end

    // ==========================================================
    // Self-timed programming
    // ==========================================================
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prog_busy_o <= 1'b0;
            prog_cnt    <= '0;
        end else if (prog_start) begin
            prog_busy_o <= 1'b1;
            prog_cnt    <= PROG_LOAD;
        end else if (prog_busy_o) begin
            prog_cnt    <= prog_cnt - CW'(1);
            if (prog_done) begin
                prog_busy_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            id_locked <= 1'b0;
        end else if (prog_done && lock_req) begin
            id_locked <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (prog_done && !lock_req) begin
            for (int i = 0; i < NP; i++) begin
                if (page_mask[i]) begin
                    if (is_id) begin
                        id_page[i] <= page_buf[i];
                    end else begin
                        mem[{wr_base[AW-1:PW], PW'(i)}] <= page_buf[i];
                    end
                end
            end
        end
    end

    // Line is only ever pulled low
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

endmodule // serial_eeprom_pin_interface

// [serial_eeprom_pin_interface_props.sv]
module eeprom_props #(
    parameter int ARRAY_BYTES = 32768,
    parameter int PROG_CYCLES = 500000
) (
    input  wire logic core_clk_i,
    input  wire logic resetn_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic sda_o,
    input  wire logic sda_oe_o,
    input  wire logic wp_i,
    input  wire logic prog_busy_o
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    // ==========================================================
    // Programming cycle length
    // ==========================================================
    logic [31:0] busy_cnt;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            busy_cnt <= '0;
        else if (prog_busy_o)
            busy_cnt <= busy_cnt + 32'h1;
        else
            busy_cnt <= '0;
    end

    // ==========================================================
    // Bus conditions
    // ==========================================================
    sequence start_seq;
        scl_i && sda_i ##1 scl_i && !sda_i;
    endsequence

    sequence stop_seq;
        scl_i && !sda_i ##1 scl_i && sda_i;
    endsequence

    open_drain_a: assert property (sda_o == 1'b0)
        else $error("data output driven high");
    drive_on_low_a: assert property ($rose(sda_oe_o) |-> !scl_i)
        else $error("data pulled while clock high");
    stable_high_a: assert property (
        $rose(scl_i) |=> $stable(sda_oe_o)[*4])
        else $error("data changed while clock high");
    bit_hold_a: assert property ($rose(sda_oe_o) |=> sda_oe_o[*8])
        else $error("pulled bit released too early");
    start_quiet_a: assert property (start_seq |-> !sda_oe_o[*3])
        else $error("data pulled around start");
    stop_quiet_a: assert property (stop_seq |=> !sda_oe_o[*4])
        else $error("data pulled after stop");
    busy_nack_a: assert property (prog_busy_o |-> !$rose(sda_oe_o))
        else $error("acknowledge during programming");
    busy_max_a: assert property (busy_cnt <= PROG_CYCLES + 1)
        else $error("programming cycle too long");
    busy_min_a: assert property (
        $fell(prog_busy_o) |-> busy_cnt >= PROG_CYCLES - 1)
        else $error("programming cycle too short");
    wp_block_a: assert property ($rose(prog_busy_o) |-> !wp_i)
        else $error("programming while protected");
    reset_idle_a: assert property (
        $rose(resetn_i) |-> (!sda_oe_o && !prog_busy_o)[*3])
        else $error("not idle after reset");
endmodule // eeprom_props

// [i2c_host_model.sv]
module i2c_host_model (
    output logic      scl_o,
    output logic      sda_low_o,
    input  wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // Quarter of a clock period; doubled for a slow master
    realtime q = 31.25;

    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic bit_io(input logic b, output logic r);
        sda_low_o = ~b;
        #q;
        scl_o = 1'b1;
        #q;
        r = sda_i;
        #q;
        scl_o = 1'b0;
        #q;
    endtask

    task automatic start();
        sda_low_o = 1'b0;
        #q;
        scl_o = 1'b1;
        #q;
        sda_low_o = 1'b1;
        #q;
        scl_o = 1'b0;
        #q;
    endtask

    task automatic stop();
        sda_low_o = 1'b1;
        #q;
        scl_o = 1'b1;
        #q;
        sda_low_o = 1'b0;
        #q;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(output logic [7:0] d, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask
endmodule // i2c_host_model

// [tb.sv]
bind serial_eeprom_pin_interface eeprom_props #(
    .ARRAY_BYTES(ARRAY_BYTES),
    .PROG_CYCLES(PROG_CYCLES)
) u_props (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .wp_i       (wp_i),
    .prog_busy_o(prog_busy_o)
);

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int         PROG_CYCLES = 400;
    localparam logic [3:0] ARR         = eeprom_pkg::TYPE_ARRAY;
    localparam logic [3:0] IDP         = eeprom_pkg::TYPE_IDPAGE;

    logic       core_clk_i = 1'b0;
    logic       resetn_i   = 1'b0;
    logic       scl;
    logic       sda_low;
    logic       sda_o;
    logic       sda_oe;
    logic       busy;
    logic       wp_en      = 1'b1;
    logic       wp_val     = 1'b0;
    logic [2:0] hw         = 3'h5;
    int         num_errors = 0;
    int         checked    = 0;
    wire logic  sda_w;
    tri0        wp_w;

    // Pull-up on the shared data wire
    assign sda_w = ~(sda_low | sda_oe);
    assign wp_w  = wp_en ? wp_val : 1'bz;

    always #5 core_clk_i = ~core_clk_i;

    serial_eeprom_pin_interface #(.PROG_CYCLES(PROG_CYCLES)) u_dut (
        .core_clk_i        (core_clk_i),
        .resetn_i          (resetn_i),
        .scl_i             (scl),
        .sda_i             (sda_w),
        .sda_o             (sda_o),
        .sda_oe_o          (sda_oe),
        .wp_i              (wp_w),
        .hw_addr_bit_zero_i(hw[0]),
        .hw_addr_bit_one_i (hw[1]),
        .hw_addr_bit_two_i (hw[2]),
        .prog_busy_o       (busy)
    );

    i2c_host_model u_host (
        .scl_o    (scl),
        .sda_low_o(sda_low),
        .sda_i    (sda_w)
    );

    task automatic end_sim();
        $display("errors %0d checked %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < PROG_CYCLES + 20) begin
            @(posedge core_clk_i);
            n++;
        end
        if (busy !== 1'b0) begin
            num_errors++;
            $display("Error at %0t: programming never ended", $time);
            end_sim();
        end
    endtask

    task automatic addr_phase(input logic [3:0] typ, input logic [14:0] a,
                              output logic ok);
        logic k0, k1, k2;
        u_host.start();
        u_host.send_byte({typ, hw, 1'b0}, k0);
        u_host.send_byte({1'b0, a[14:8]}, k1);
        u_host.send_byte(a[7:0], k2);
        ok = k0 & k1 & k2;
    endtask

    task automatic wr(input logic [3:0] typ, input logic [14:0] a,
                      input logic [7:0] d[$], input logic ok_exp);
        logic ok, k;
        addr_phase(typ, a, ok);
        cmp({7'h0, ok}, 8'h01);
        foreach (d[i]) begin
            u_host.send_byte(d[i], k);
            if (i == 0) cmp({7'h0, k}, {7'h0, ok_exp});
        end
        u_host.stop();
        repeat (4) @(negedge core_clk_i);
        cmp({7'h0, busy}, {7'h0, ok_exp});
        u_host.start();
        u_host.send_byte({typ, hw, 1'b0}, k);
        u_host.stop();
        if (ok_exp) cmp({7'h0, k}, 8'h00);
        wait_idle();
    endtask

    task automatic rd(input logic [3:0] typ, input logic [14:0] a,
                      input logic [7:0] exp[$]);
        logic       ok, k;
        logic [7:0] got;
        addr_phase(typ, a, ok);
        u_host.start();
        u_host.send_byte({typ, hw, 1'b1}, k);
        cmp({6'h0, ok, k}, 8'h03);
        foreach (exp[i]) begin
            u_host.recv_byte(got, i == exp.size() - 1);
            cmp(got, exp[i]);
        end
        u_host.stop();
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic page_test();
        logic [7:0] d[$];
        logic [7:0] e[$];
        for (int i = 0; i < 64; i++) begin
            d.push_back(8'(8'h30 + i));
            e.push_back(8'(8'h30 + (i + 59) % 64));
        end
        wr(ARR, 15'h0045, d, 1'b1);
        rd(ARR, 15'h0040, e);
        wr(ARR, 15'h0000, '{8'h5a}, 1'b1);
        wr(ARR, 15'h7fff, '{8'hc3, 8'h3c}, 1'b1);
        rd(ARR, 15'h7fff, '{8'hc3, 8'h5a});
        rd(ARR, 15'h7fc0, '{8'h3c});
    endtask

    task automatic strap_test();
        logic k;
        for (int s = 0; s < 2; s++) begin
            @(negedge core_clk_i);
            hw = s ? 3'h2 : 3'h5;
            repeat (4) @(negedge core_clk_i);
            for (int h = 0; h < 8; h++) begin
                u_host.start();
                u_host.send_byte({ARR, 3'(h), 1'b0}, k);
                u_host.stop();
                cmp({7'h0, k}, {7'h0, 3'(h) == hw});
            end
            u_host.start();
            u_host.send_byte({4'h5, hw, 1'b0}, k);
            u_host.stop();
            cmp({7'h0, k}, 8'h00);
        end
        @(negedge core_clk_i);
        hw = 3'h5;
        repeat (4) @(negedge core_clk_i);
    endtask

    task automatic wp_test();
        wr(ARR, 15'h1234, '{8'h11}, 1'b1);
        @(negedge core_clk_i);
        wp_val = 1'b1;
        repeat (4) @(negedge core_clk_i);
        wr(ARR, 15'h1234, '{8'h77}, 1'b0);
        rd(ARR, 15'h1234, '{8'h11});
        @(negedge core_clk_i);
        wp_en = 1'b0;
        repeat (4) @(negedge core_clk_i);
        wr(ARR, 15'h1233, '{8'h66, 8'h99}, 1'b1);
        u_host.q = 62.5;
        rd(ARR, 15'h1233, '{8'h66, 8'h99});
        u_host.q = 31.25;
    endtask

    task automatic idpage_test();
        wr(IDP, 15'h0003, '{8'hab}, 1'b1);
        rd(IDP, 15'h0003, '{8'hab});
        wr(IDP, 15'h0400, '{8'h00}, 1'b1);
        wr(IDP, 15'h0003, '{8'hcd}, 1'b0);
        rd(IDP, 15'h0003, '{8'hab});
        wr(ARR, 15'h0003, '{8'hcd}, 1'b1);
        rd(ARR, 15'h0003, '{8'hcd});
    endtask

    initial begin
        repeat (8) @(posedge core_clk_i);
        @(negedge core_clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        page_test();
        strap_test();
        wp_test();
        idpage_test();
        end_sim();
    end
endmodule // tb
